/* File: design/ilc_consts.svh */
/*
 Offsets, field positions, reset values and map geometry for the input
 link error and channel control registers. Assumes byte addressing
 with one aligned 32-bit word per register and four channel pages.
*/
// Contract
// - Bits 0-19 flag parity errors per data pin across enabled links.
// - Bits 20-23 flag a parity error on each link.
// - Bits 24-27 flag a protocol error on each link.
// - Bits 28-31 flag link down on each link.
// - Only enabled links feed the error map; disabled links are ignored.
// - Error map bits stay set until the error-clear pulse.
// - Bits 0-15 count cycles with any enabled parity or protocol error.
// - Bits 16-31 count cycles with any enabled link down.
// - Counters are zero after reset and zeroed by error-clear.
// - Pulse bits 0-3 reset the matching link; read as zero.
// - Pulse bit 4 clears all error flags and counters.
// - Pulse bit 5 empties input FIFOs; not while events arrive.
// - Pulse bit 6 zeroes the depth monitor histogram.
// - Busy when occupancy exceeds threshold; all-ones threshold blocks busy.
// - Channel version returns module type, code type, revision from 1.
// - Control bit 0 enables link input; zero gives bus FIFO access.
// - Control bit 1 selects 20-bit words, else 16-bit.
// - Control bit 2 halts the bunch-number FIFO and opens bus access.
// - Status shows link-ready, FIFO full, empty, partial on fixed bits.
// - Slice count holds primary 1-7 and secondary 0-31 header fields.
// - Sub-slice register packs six 5-bit maps in bits 0-29.
// - A sub-slice is discarded when its map bit is set.
`ifndef ILC_CONSTS_SVH
`define ILC_CONSTS_SVH

// Common register byte offsets
`define ILC_OFS_ERR_MAP   18'h00008
`define ILC_OFS_ERR_CNT   18'h0000C
`define ILC_OFS_PULSE     18'h00010
`define ILC_OFS_DBUSY     18'h00014
`define ILC_OFS_EBUSY     18'h00018
`define ILC_OFS_BBUSY     18'h0001C

// Channel page offsets, page selected by address bits 17:16
`define ILC_OFS_CH_VER    16'h0800
`define ILC_OFS_CH_CTRL   16'h0804
`define ILC_OFS_CH_STAT   16'h0808
`define ILC_OFS_CH_SLICE  16'h080C
`define ILC_OFS_CH_SUB    16'h0810

// Error map field positions
`define ILC_MAP_PAR_LSB   20
`define ILC_MAP_PROTO_LSB 24
`define ILC_MAP_DOWN_LSB  28

// Pulse bits
`define ILC_PLS_CLR_ERR   4
`define ILC_PLS_FLUSH     5
`define ILC_PLS_MON_CLR   6

// Control bits
`define ILC_CTRL_ENABLE   0
`define ILC_CTRL_WIDTH20  1
`define ILC_CTRL_BN_HOLD  2

// Slice count field positions
`define ILC_SLC_SEC_LSB   8

// Reset values and disabling thresholds
`define ILC_DBUSY_OFF     13'h1FFF
`define ILC_EBUSY_OFF     9'h1FF
`define ILC_BBUSY_OFF     9'h1FF

// Map geometry
`define ILC_COMPONENTS    3'h6
`define ILC_SUBSLICES     3'h5
`define ILC_MAP_WIDTH     5

`endif

/* File: design/ilc_pkg.sv */
/*
 Types shared by the input link register bank: link pin groups,
 FIFO state, occupancy, per-channel configuration and sub-slice tags.
 Assumes four links, each with 20 data pins.
*/
package ilc_pkg;
    // Per-link signals seen from the receiver
    typedef struct packed {
        logic [19:0] par_pins;
        logic        proto_err;
        logic        link_down;
        logic        link_ready;
    } ilc_link_in_type;

    // FIFO flags from the channel logic
    typedef struct packed {
        logic data_full;
        logic data_empty;
        logic data_part;
        logic evt_full;
        logic evt_empty;
        logic evt_part;
    } ilc_fifo_stat_type;

    // FIFO occupancies for busy
    typedef struct packed {
        logic [12:0] data_occ;
        logic [8:0]  evt_occ;
        logic [8:0]  bunch_occ;
    } ilc_occ_type;

    // Configuration driven to a channel
    typedef struct packed {
        logic        enable;
        logic        width20;
        logic        bunch_hold;
        logic [2:0]  primary_slice_header_field;
        logic [4:0]  secondary_slice_header_field;
        logic [29:0] discard_map;
    } ilc_chan_cfg_type;

    // One sub-slice offered for the discard decision
    typedef struct packed {
        logic       valid;
        logic [2:0] comp;
        logic [2:0] slice;
    } ilc_subslice_type;
endpackage

/* File: design/ilc_input_regs.sv */
/*
 Register bank for the input stage: error map and counters, pulse
 controls, FIFO busy thresholds and per-channel control for four links.
 Assumes link inputs are asynchronous and FIFO flags come from clk_sys_in.
 Assumes one-cycle read or write strobes, never both at once,
 each answered by a one-cycle acknowledge.
 Occupancies and offered sub-slices share clk_sys_in: no sync.
*/
`timescale 1ns/1ps
`include "ilc_consts.svh"
`default_nettype none
module ilc_input_regs
    import ilc_pkg::*;
#(
    parameter logic [15:0] MODULE_TYPE = 16'h0A5A, // Arbitrary value
    parameter logic [7:0]  CODE_TYPE   = 8'h01,    // Arbitrary value
    parameter logic [7:0]  REVISION    = 8'h01
) (
    // Clock and reset
    input  wire logic                    clk_sys_in,
    input  wire logic                    rst_n_in,
    // Register port
    input  wire logic [17:0]             reg_addr_in,
    input  wire logic                    reg_wr_in,
    input  wire logic                    reg_rd_in,
    input  wire logic [31:0]             reg_wdata_in,
    output logic      [31:0]             reg_rdata_out,
    output logic                         reg_ack_out,
    // Link and FIFO state
    input  wire ilc_link_in_type   [3:0] link_in,
    input  wire ilc_fifo_stat_type [3:0] fifo_stat_in,
    input  wire ilc_occ_type       [3:0] occ_in,
    input  wire ilc_subslice_type  [3:0] subslice_in,
    // Controls
    output logic      [3:0]              link_reset_out,
    output logic                         fifo_flush_out,
    output logic                         depth_mon_clear_out,
    output logic                         busy_out,
    output ilc_chan_cfg_type [3:0]       chan_cfg_out,
    output logic      [3:0]              discard_out
);

    // Sync stages and agreed link view
    ilc_link_in_type [3:0] s1_q;
    ilc_link_in_type [3:0] s2_q;
    ilc_link_in_type [3:0] s3_q;
    ilc_link_in_type [3:0] lnk_q;

    // Error map, hits and counters
    logic [31:0]           err_map_q;
    logic [31:0]           hits;
    logic                  any_err;
    logic                  any_down;
    logic [15:0]           err_cnt_q;
    logic [15:0]           down_cnt_q;

    // Pulses and busy thresholds
    logic [6:0]            pulse_q;
    logic [12:0]           dthr_q;
    logic [8:0]            ethr_q;
    logic [8:0]            bthr_q;
    logic                  busy_d;

    // Per-channel configuration
    ilc_chan_cfg_type [3:0] cfg_q;

    // Address decode and read path
    logic [31:0]           rd_mux;
    logic                  common_pg;
    logic [1:0]            ch;
    logic [15:0]           ch_ofs;
    logic                  wr_pulse;

    // Address split into common page and channel page
    // Page zero also holds the common block
    assign ch        = reg_addr_in[17:16];
    assign ch_ofs    = reg_addr_in[15:0];
    assign common_pg = (ch == 2'h0) && (ch_ofs[15:8] == 8'h00);
    assign wr_pulse  = reg_wr_in && (reg_addr_in == `ILC_OFS_PULSE);

    // Three-stage sync; a change is taken only once stages two and three agree
    // Stage one feeds stage two only
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lnk_q <= '0;
        end else begin
            s1_q  <= link_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            // Disagreeing stages keep the old view
            lnk_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lnk_q);
        end
    end

    // Error indications gated by channel enable
    // Pins of all enabled links share bits 0-19
    always_comb begin
        hits     = '0;
        any_err  = 1'b0;
        any_down = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (cfg_q[i].enable) begin
                hits[19:0] = hits[19:0] | lnk_q[i].par_pins;
                hits[`ILC_MAP_PAR_LSB + i]   = |lnk_q[i].par_pins;
                hits[`ILC_MAP_PROTO_LSB + i] = lnk_q[i].proto_err;
                hits[`ILC_MAP_DOWN_LSB + i]  = lnk_q[i].link_down;
                any_err  = any_err | (|lnk_q[i].par_pins) | lnk_q[i].proto_err;
                any_down = any_down | lnk_q[i].link_down;
            end
        end
    end

    // Sticky map; a new error in the clear cycle survives the clear
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_map_q <= '0;
        end else if (pulse_q[`ILC_PLS_CLR_ERR]) begin
            err_map_q <= hits;
        end else begin
            err_map_q <= err_map_q | hits;
        end
    end

    // Cycle counters; they wrap rather than saturate
    // Clear cycle counts its own hit, none lost
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_cnt_q  <= '0;
            down_cnt_q <= '0;
        end else if (pulse_q[`ILC_PLS_CLR_ERR]) begin
            err_cnt_q  <= {15'h0000, any_err};
            down_cnt_q <= {15'h0000, any_down};
        end else begin
            err_cnt_q  <= err_cnt_q + {15'h0000, any_err};
            down_cnt_q <= down_cnt_q + {15'h0000, any_down};
        end
    end

    // Pulse bits live one cycle and fall back unaided
    // A written zero loads zero: no effect
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pulse_q <= '0;
        end else if (wr_pulse) begin
            pulse_q <= reg_wdata_in[6:0];
        end else begin
            pulse_q <= '0;
        end
    end

    // Pulse outputs straight from the pulse flops
    assign link_reset_out      = pulse_q[3:0];
    assign fifo_flush_out      = pulse_q[`ILC_PLS_FLUSH];
    assign depth_mon_clear_out = pulse_q[`ILC_PLS_MON_CLR];

    // Busy thresholds reset to all ones so nothing is busy before setup
    // Upper write bits are dropped
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dthr_q <= `ILC_DBUSY_OFF;
            ethr_q <= `ILC_EBUSY_OFF;
            bthr_q <= `ILC_BBUSY_OFF;
        end else if (reg_wr_in) begin
            if (reg_addr_in == `ILC_OFS_DBUSY) begin
                dthr_q <= reg_wdata_in[12:0];
            end
            if (reg_addr_in == `ILC_OFS_EBUSY) begin
                ethr_q <= reg_wdata_in[8:0];
            end
            if (reg_addr_in == `ILC_OFS_BBUSY) begin
                bthr_q <= reg_wdata_in[8:0];
            end
        end
    end

    // Busy from any channel's FIFO above its threshold
    // Equal to the threshold is not busy yet
    always_comb begin
        busy_d = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if ((dthr_q != `ILC_DBUSY_OFF) && (occ_in[i].data_occ > dthr_q)) begin
                busy_d = 1'b1;
            end
            if ((ethr_q != `ILC_EBUSY_OFF) && (occ_in[i].evt_occ > ethr_q)) begin
                busy_d = 1'b1;
            end
            if ((bthr_q != `ILC_BBUSY_OFF) && (occ_in[i].bunch_occ > bthr_q)) begin
                busy_d = 1'b1;
            end
        end
    end

    // Registered so busy leaves from a flop
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= busy_d;
        end
    end

    // Channel configuration; enable resets low to keep noisy links out
    // Common offsets never match these items
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q <= '0;
        end else if (reg_wr_in) begin
            case (ch_ofs)
                `ILC_OFS_CH_CTRL: begin
                    cfg_q[ch].enable     <= reg_wdata_in[`ILC_CTRL_ENABLE];
                    cfg_q[ch].width20    <= reg_wdata_in[`ILC_CTRL_WIDTH20];
                    cfg_q[ch].bunch_hold <= reg_wdata_in[`ILC_CTRL_BN_HOLD];
                end
                `ILC_OFS_CH_SLICE: begin
                    cfg_q[ch].primary_slice_header_field <= reg_wdata_in[2:0];
                    cfg_q[ch].secondary_slice_header_field <=
                        reg_wdata_in[`ILC_SLC_SEC_LSB +: 5];
                end
                `ILC_OFS_CH_SUB: begin
                    cfg_q[ch].discard_map <= reg_wdata_in[29:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Configuration straight from its flops
    assign chan_cfg_out = cfg_q;

    // Discard decision per offered sub-slice, one cycle later
    // Widen before the multiply; index reaches 29
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            discard_out <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                discard_out[i] <= subslice_in[i].valid
                    && (subslice_in[i].comp < `ILC_COMPONENTS)
                    && (subslice_in[i].slice < `ILC_SUBSLICES)
                    && cfg_q[i].discard_map[(5'(subslice_in[i].comp) * 5'h05)
                                            + 5'(subslice_in[i].slice)];
            end
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    // Status is not gated by the enable
    always_comb begin
        rd_mux = '0;
        if (common_pg) begin
            case (reg_addr_in)
                `ILC_OFS_ERR_MAP: rd_mux = err_map_q;
                `ILC_OFS_ERR_CNT: rd_mux = {down_cnt_q, err_cnt_q};
                `ILC_OFS_PULSE:   rd_mux = '0;
                `ILC_OFS_DBUSY:   rd_mux = {19'h00000, dthr_q};
                `ILC_OFS_EBUSY:   rd_mux = {23'h000000, ethr_q};
                `ILC_OFS_BBUSY:   rd_mux = {23'h000000, bthr_q};
                default:          rd_mux = '0;
            endcase
        end else begin
            case (ch_ofs)
                `ILC_OFS_CH_VER:   rd_mux = {REVISION, CODE_TYPE, MODULE_TYPE};
                `ILC_OFS_CH_CTRL:  rd_mux = {29'h00000000, cfg_q[ch].bunch_hold,
                                             cfg_q[ch].width20, cfg_q[ch].enable};
                `ILC_OFS_CH_STAT:  rd_mux = {25'h0000000,
                                             fifo_stat_in[ch].evt_part,
                                             fifo_stat_in[ch].data_part,
                                             fifo_stat_in[ch].evt_empty,
                                             fifo_stat_in[ch].data_empty,
                                             fifo_stat_in[ch].evt_full,
                                             fifo_stat_in[ch].data_full,
                                             lnk_q[ch].link_ready};
                `ILC_OFS_CH_SLICE: rd_mux = {19'h00000,
                                             cfg_q[ch].secondary_slice_header_field,
                                             5'h00, cfg_q[ch].primary_slice_header_field};
                `ILC_OFS_CH_SUB:   rd_mux = {2'h0, cfg_q[ch].discard_map};
                default:           rd_mux = '0;
            endcase
        end
    end

    // Answer one cycle after each access
    // Data is zero outside reads
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= '0;
            reg_ack_out   <= 1'b0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : 32'h00000000;
            reg_ack_out   <= reg_rd_in | reg_wr_in;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // Pulse register
    pulse_self_clr_a: assert property (!wr_pulse |=> pulse_q == 7'h00)
        else $error("pulse bits did not self clear");

    link_reset_a: assert property (wr_pulse |=> link_reset_out == $past(reg_wdata_in[3:0]))
        else $error("link reset pulse mismatch");

    flush_pulse_a: assert property (wr_pulse && reg_wdata_in[`ILC_PLS_FLUSH]
        |=> fifo_flush_out ##1 (!fifo_flush_out || $past(wr_pulse)))
        else $error("fifo flush pulse wrong");

    mon_clear_a: assert property (wr_pulse && reg_wdata_in[6] |=> depth_mon_clear_out)
        else $error("monitor clear missing");

    // Error map; a set wins over the clear
    map_clear_a: assert property (pulse_q[4] |=> err_map_q == $past(hits))
        else $error("error map not cleared");

    map_sticky_a: assert property (!pulse_q[4]
        |=> (err_map_q & $past(err_map_q)) == $past(err_map_q))
        else $error("error map lost a bit");

    disabled_quiet_a: assert property (((hits[23:20] | hits[27:24] | hits[31:28])
        & ~{cfg_q[3].enable, cfg_q[2].enable, cfg_q[1].enable, cfg_q[0].enable}) == 4'h0)
        else $error("disabled link reached the map");

    // Cycle counters
    err_count_a: assert property (!pulse_q[4] && any_err
        |=> err_cnt_q == $past(err_cnt_q) + 16'h0001)
        else $error("error counter did not step");

    down_count_a: assert property (!pulse_q[4] && !any_down |=> $stable(down_cnt_q))
        else $error("down counter moved");

    down_step_a: assert property (!pulse_q[4] && any_down
        |=> down_cnt_q == $past(down_cnt_q) + 16'h0001)
        else $error("down counter did not step");

    cnt_clear_a: assert property (pulse_q[4] && !any_err && !any_down
        |=> {err_cnt_q, down_cnt_q} == 32'h00000000)
        else $error("counters not zeroed");

    // Read-back, busy and configuration
    pulse_read_a: assert property (reg_rd_in && reg_addr_in == `ILC_OFS_PULSE
        |=> reg_rdata_out == 32'h00000000)
        else $error("pulse register read nonzero");

    busy_off_a: assert property (dthr_q == `ILC_DBUSY_OFF && ethr_q == `ILC_EBUSY_OFF
        && bthr_q == `ILC_BBUSY_OFF |=> !busy_out)
        else $error("busy with all thresholds off");

    cfg_enable_a: assert property (reg_wr_in && reg_addr_in == {2'h0, `ILC_OFS_CH_CTRL}
        |=> cfg_q[0].enable == $past(reg_wdata_in[`ILC_CTRL_ENABLE]))
        else $error("channel enable not taken");

    cfg_width_a: assert property (reg_wr_in && reg_addr_in == {2'h0, `ILC_OFS_CH_CTRL}
        |=> cfg_q[0].width20 == $past(reg_wdata_in[`ILC_CTRL_WIDTH20]))
        else $error("width select not taken");

    // Main scenarios
    clear_seen_c: cover property (pulse_q[4] ##1 err_map_q == 32'h00000000);
    disabled_fault_c: cover property (!cfg_q[1].enable && lnk_q[1].link_down);
    busy_seen_c: cover property (!busy_out ##1 busy_out);
    discard_seen_c: cover property (discard_out != 4'h0);
    error_seen_c: cover property (any_err ##1 err_map_q != 32'h00000000);

endmodule
`default_nettype wire

/* File: testbench/ilc_link_model.sv */
/*
 Stand-in for the four serial link receivers facing the register bank.
 Assumes bench commands change just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module ilc_link_model
    import ilc_pkg::*;
(
    // Commands from the bench
    input  wire logic [1:0]          mode_in,
    input  wire logic [1:0]          sel_in,
    input  wire logic [4:0]          pin_in,
    input  wire logic                ready_in,
    // Links toward the block
    output var  ilc_link_in_type [3:0] link_out
);
    // Only the selected link shows a fault; the rest stay clean
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            link_out[i] = '0;
            link_out[i].link_ready = ready_in;
            if (sel_in == i[1:0]) begin
                link_out[i].proto_err = (mode_in == 2'h1);
                link_out[i].par_pins  = (mode_in == 2'h2) ? (20'h1 << pin_in) : 20'h0;
                link_out[i].link_down = (mode_in == 2'h3);
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb_ilc_input_regs.sv */
/*
 Self-checking bench for the input link register bank.
 Assumes one-cycle strobes answered by a one-cycle acknowledge.
*/
`timescale 1ns/1ps
`include "ilc_consts.svh"
`default_nettype none
module tb_ilc_input_regs;
    import ilc_pkg::*;
    localparam logic [31:0] VERSION_EXP = 32'h0101_0A5A; // Arbitrary identity
    logic                    clk_sys_in = 1'b0;
    logic                    rst_n_in   = 1'b0;
    logic [17:0]             reg_addr   = '0;
    logic                    reg_wr     = 1'b0;
    logic                    reg_rd     = 1'b0;
    logic [31:0]             reg_wdata  = '0;
    logic [31:0]             reg_rdata;
    logic                    reg_ack;
    ilc_link_in_type   [3:0] link;
    ilc_fifo_stat_type [3:0] fstat      = '0;
    ilc_occ_type       [3:0] occ        = '0;
    ilc_subslice_type  [3:0] sub        = '0;
    logic [3:0]              lrst;
    logic                    flush;
    logic                    mclr;
    logic                    busy;
    ilc_chan_cfg_type  [3:0] cfg;
    logic [3:0]              disc;
    logic [1:0]              mode       = '0;
    logic [1:0]              sel        = '0;
    logic [4:0]              pin        = '0;
    logic                    ready      = 1'b1;
    int                      failures   = 0;
    int                      compares   = 0;
    logic [31:0]             rd_val;
    logic [6:0]              pls_seen;
    logic [6:0]              pls_after;

    ilc_input_regs #(.MODULE_TYPE(16'h0A5A), .CODE_TYPE(8'h01), .REVISION(8'h01)) u_ilc_input_regs (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .reg_ack_out(reg_ack),
        .link_in(link), .fifo_stat_in(fstat), .occ_in(occ), .subslice_in(sub),
        .link_reset_out(lrst), .fifo_flush_out(flush), .depth_mon_clear_out(mclr),
        .busy_out(busy), .chan_cfg_out(cfg), .discard_out(disc));

    ilc_link_model u_ilc_link_model (
        .mode_in(mode), .sel_in(sel), .pin_in(pin), .ready_in(ready), .link_out(link));

    // Free-running system clock
    always #25 clk_sys_in = ~clk_sys_in;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [17:0] chreg(input int c, input logic [15:0] o);
        return {c[1:0], o};
    endfunction

    // Strobe lasts one cycle; pulses are caught in the cycle after it
    task automatic reg_write(input logic [17:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_wr = 1'b0;
        pls_seen = {mclr, flush, 1'b0, lrst};
        chk({31'h0, reg_ack}, 32'h1);
        @(posedge clk_sys_in);
        #1;
        pls_after = {mclr, flush, 1'b0, lrst};
    endtask

    task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys_in);
        #1;
        reg_rd = 1'b0;
        rd_val = reg_rdata;
        chk({31'h0, reg_ack}, 32'h1);
        chk(rd_val, exp);
        @(posedge clk_sys_in);
        #1;
    endtask

    // Hold a fault long enough for the two-sample agreement
    task automatic inject(input logic [1:0] m, input logic [1:0] s, input logic [4:0] p, input int n);
        mode = m;
        sel = s;
        pin = p;
        repeat (n) @(posedge clk_sys_in);
        #1;
        mode = 2'h0;
        @(posedge clk_sys_in);
        #1;
    endtask

    task automatic busy_case(input int k, input logic [12:0] v, input logic exp);
        occ = '0;
        case (k)
            0: occ[3].data_occ = v;
            1: occ[3].evt_occ = v[8:0];
            default: occ[3].bunch_occ = v[8:0];
        endcase
        @(posedge clk_sys_in);
        #1;
        chk({31'h0, busy}, {31'h0, exp});
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog sized well above the sequence length
    initial begin
        #200000;
        failures++;
        give_verdict();
    end

    initial begin
        fstat[3] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        fstat[2] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        repeat (4) @(posedge clk_sys_in);
        #1;
        rst_n_in = 1'b1;
        rd_chk(`ILC_OFS_ERR_MAP, 32'h0);
        rd_chk(`ILC_OFS_ERR_CNT, 32'h0);
        rd_chk(`ILC_OFS_PULSE, 32'h0);
        rd_chk(`ILC_OFS_DBUSY, 32'h1FFF);
        rd_chk(`ILC_OFS_EBUSY, 32'h1FF);
        rd_chk(`ILC_OFS_BBUSY, 32'h1FF);
        rd_chk(18'h00020, 32'h0);
        for (int c = 0; c < 4; c++) begin
            rd_chk(chreg(c, `ILC_OFS_CH_VER), VERSION_EXP);
        end
        // Enables stay low from power-up until written here
        reg_write(chreg(0, `ILC_OFS_CH_CTRL), 32'hFFFF_FFFF);
        rd_chk(chreg(0, `ILC_OFS_CH_CTRL), 32'h7);
        chk({29'h0, cfg[0].enable, cfg[0].width20, cfg[0].bunch_hold}, 32'h7);
        reg_write(chreg(0, `ILC_OFS_CH_CTRL), 32'h2);
        chk({29'h0, cfg[0].enable, cfg[0].width20, cfg[0].bunch_hold}, 32'h2);
        reg_write(chreg(0, `ILC_OFS_CH_CTRL), 32'h1);
        reg_write(chreg(2, `ILC_OFS_CH_CTRL), 32'h1);
        rd_chk(chreg(3, `ILC_OFS_CH_STAT), 32'h53);
        rd_chk(chreg(2, `ILC_OFS_CH_STAT), 32'h2D);
        reg_write(chreg(1, `ILC_OFS_CH_SLICE), 32'hFFFF_FFFF);
        rd_chk(chreg(1, `ILC_OFS_CH_SLICE), 32'h1F07);
        chk({24'h0, cfg[1].primary_slice_header_field, cfg[1].secondary_slice_header_field},
            32'hFF);
        reg_write(chreg(1, `ILC_OFS_CH_SUB), 32'hFFFF_FFFF);
        rd_chk(chreg(1, `ILC_OFS_CH_SUB), 32'h3FFF_FFFF);
        reg_write(chreg(1, `ILC_OFS_CH_SUB), 32'h400);
        chk({2'h0, cfg[1].discard_map}, 32'h400);
        sub[1] = '{1'b1, 3'h2, 3'h0};
        @(posedge clk_sys_in);
        #1;
        chk({28'h0, disc}, 32'h2);
        sub[1].slice = 3'h1;
        @(posedge clk_sys_in);
        #1;
        chk({28'h0, disc}, 32'h0);
        sub[1] = '0;
        // Link 1 stays disabled, so its faults must leave no trace
        inject(2'h1, 2'h0, 5'h0, 6);
        inject(2'h3, 2'h1, 5'h0, 5);
        inject(2'h2, 2'h2, 5'h5, 3);
        inject(2'h3, 2'h0, 5'h0, 4);
        inject(2'h1, 2'h1, 5'h0, 3);
        repeat (8) @(posedge clk_sys_in);
        #1;
        rd_chk(`ILC_OFS_ERR_MAP, 32'h1140_0020);
        rd_chk(`ILC_OFS_ERR_CNT, 32'h0004_0009);
        rd_chk(`ILC_OFS_ERR_MAP, 32'h1140_0020);
        reg_write(`ILC_OFS_PULSE, 32'h0);
        chk({25'h0, pls_seen}, 32'h0);
        rd_chk(`ILC_OFS_ERR_MAP, 32'h1140_0020);
        // Flush is only pulsed here while no traffic arrives
        for (int i = 0; i < 7; i++) begin
            reg_write(`ILC_OFS_PULSE, 32'h1 << i);
            chk({25'h0, pls_seen}, (32'h1 << i) & 32'h6F);
            chk({25'h0, pls_after}, 32'h0);
            rd_chk(`ILC_OFS_PULSE, 32'h0);
        end
        rd_chk(`ILC_OFS_ERR_MAP, 32'h0);
        rd_chk(`ILC_OFS_ERR_CNT, 32'h0);
        for (int k = 0; k < 3; k++) begin
            reg_write(`ILC_OFS_DBUSY + 18'(4 * k), 32'h5);
            busy_case(k, 13'h6, 1'b1);
            busy_case(k, 13'h5, 1'b0);
            reg_write(`ILC_OFS_DBUSY + 18'(4 * k), (k == 0) ? 32'h1FFF : 32'h1FF);
            busy_case(k, 13'h1FFF, 1'b0);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
